/* File: verilog/halfword_load_defs.svh */
// constants for the signed halfword load unit
`ifndef HALFWORD_LOAD_DEFS_SVH
`define HALFWORD_LOAD_DEFS_SVH

// ****************************************
// issue slots that may carry a data-memory op
// ****************************************
`define DMEM_SLOT_LO 3'h4
`define DMEM_SLOT_HI 3'h5

// ****************************************
// field positions and widths
// ****************************************
`define GUARD_LSB 0
`define ADDR_ALIGN_BIT 0
`define HALF_MSB 15
`define EXT_WIDTH 16
`define DISP_SIGN_BIT 6
`define DISP_EXT_WIDTH 24

// ****************************************
// reset values
// ****************************************
`define WORD_ZERO 32'h0000_0000
`define DEST_ZERO 7'h00

`endif

/* File: verilog/halfword_load_pkg.sv */
// types shared by the signed halfword load unit
package halfword_load_pkg;
    typedef logic [31:0] word_t;
    typedef logic [15:0] half_t;
    typedef logic [6:0] disp_t;
    typedef logic [6:0] dest_t;
    typedef logic [2:0] slot_t;
endpackage

/* File: verilog/halfword_order.sv */
// byte ordering and sign extension of a fetched halfword
`timescale 1ns/10ps
`include "halfword_load_defs.svh"

module halfword_order
    import halfword_load_pkg::*;
(
    input wire half_t raw,
    input wire logic little_endian,
    output word_t value
);
    // ****************************************
    // ordering
    // ****************************************
    // raw[7:0] is the byte at the effective address, raw[15:8] the next one
    wire half_t ordered;
    assign ordered = little_endian ? raw : {raw[7:0], raw[15:8]};

    // ****************************************
    // sign extension
    // ****************************************
    // replicate the halfword sign across the upper bits
    assign value = {{`EXT_WIDTH{ordered[`HALF_MSB]}}, ordered};
endmodule

/* File: verilog/signed_halfword_load_unit.sv */
// signed halfword load unit between issue logic and the data cache
`timescale 1ns/10ps
`include "halfword_load_defs.svh"

module signed_halfword_load_unit
    import halfword_load_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire slot_t issue_slot,
    input wire logic use_disp,
    input wire word_t first_source_operand,
    input wire disp_t disp,
    input wire logic guard_present,
    input wire word_t guard,
    input wire dest_t dest_idx,
    input wire logic program_status_word_le,
    output logic mem_req,
    output word_t mem_addr,
    input wire half_t mem_rd_data,
    output logic wb_valid,
    output dest_t wb_dest,
    output word_t wb_data
);
    // ****************************************
    // issue decode
    // ****************************************
    // memory ops only leave from the two data-memory slots
    wire slot_ok;
    wire accept;
    wire guard_ok;
    wire go;
    assign slot_ok = (issue_slot == `DMEM_SLOT_LO) || (issue_slot == `DMEM_SLOT_HI);
    assign accept = issue_valid && slot_ok;
    // an absent guard counts as true
    assign guard_ok = !guard_present || guard[`GUARD_LSB];
    assign go = accept && guard_ok;

    // ****************************************
    // effective address
    // ****************************************
    // the plain form is the displacement form with the displacement forced to zero
    // the 7-bit field counts halfwords, so the byte offset is always even and
    // spans -128 to 126; an odd offset simply cannot be encoded
    wire disp_t disp_used;
    wire word_t disp_ext;
    wire word_t eff_addr;
    assign disp_used = use_disp ? disp : 7'h00;
    assign disp_ext = {{`DISP_EXT_WIDTH{disp_used[`DISP_SIGN_BIT]}}, disp_used, 1'b0};
    assign eff_addr = first_source_operand + disp_ext;

    // ****************************************
    // stage one: address to the cache
    // ****************************************
    logic s1_valid_ff;
    word_t s1_addr_ff;
    dest_t s1_dest_ff;
    logic s1_le_ff;

    // a false guard never reaches the cache, so no status bits move
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_valid_ff <= 1'b0;
            s1_addr_ff <= `WORD_ZERO;
            s1_dest_ff <= `DEST_ZERO;
            s1_le_ff <= 1'b0;
        end else begin
            s1_valid_ff <= go;
            s1_addr_ff <= eff_addr;
            s1_dest_ff <= dest_idx;
            s1_le_ff <= program_status_word_le;
        end
    end

    // odd addresses are rounded down rather than trapped; the data is then
    // meaningless but harmless, which the op allows. the register aperture is
    // not decoded here: a halfword load there returns whatever the cache gives
    assign mem_req = s1_valid_ff;
    assign mem_addr = {s1_addr_ff[31:1], 1'b0};

    // ****************************************
    // stage two: waiting for the cache data
    // ****************************************
    logic s2_valid_ff;
    dest_t s2_dest_ff;
    logic s2_le_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s2_valid_ff <= 1'b0;
            s2_dest_ff <= `DEST_ZERO;
            s2_le_ff <= 1'b0;
        end else begin
            s2_valid_ff <= s1_valid_ff;
            s2_dest_ff <= s1_dest_ff;
            s2_le_ff <= s1_le_ff;
        end
    end

    // ****************************************
    // byte ordering and extension
    // ****************************************
    word_t loaded;

    halfword_order u_order (
        .raw(mem_rd_data),
        .little_endian(s2_le_ff),
        .value(loaded)
    );

    // ****************************************
    // stage three: writeback
    // ****************************************
    logic wb_valid_ff;
    dest_t wb_dest_ff;
    word_t wb_data_ff;

    // data is held when no write happens so the port does not toggle needlessly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_valid_ff <= 1'b0;
            wb_dest_ff <= `DEST_ZERO;
            wb_data_ff <= `WORD_ZERO;
        end else begin
            wb_valid_ff <= s2_valid_ff;
            if (s2_valid_ff) begin
                wb_dest_ff <= s2_dest_ff;
                wb_data_ff <= loaded;
            end
        end
    end

    assign wb_valid = wb_valid_ff;
    assign wb_dest = wb_dest_ff;
    assign wb_data = wb_data_ff;

    // ****************************************
    // checks
    // ****************************************
    // independent address model for the displacement form
    wire word_t chk_disp_addr;
    assign chk_disp_addr = first_source_operand + (word_t'(signed'(disp)) << 1);

    AST_LATENCY: assert property (
        @(posedge clk) disable iff (rst)
        go |-> ##3 (wb_valid && wb_dest == $past(dest_idx, 3))
    ) else $error("guarded-true load did not write back after three cycles");

    AST_SLOT_ONLY: assert property (
        @(posedge clk) disable iff (rst)
        issue_valid && !slot_ok |-> ##1 !mem_req ##2 !wb_valid
    ) else $error("load from a non-memory slot took effect");

    AST_GUARD_FALSE: assert property (
        @(posedge clk) disable iff (rst)
        issue_valid && guard_present && !guard[0] |-> ##1 !mem_req ##2 !wb_valid
    ) else $error("false guard caused a cache access or a write");

    AST_GUARD_TRUE_REQ: assert property (
        @(posedge clk) disable iff (rst)
        go |=> mem_req
    ) else $error("true or absent guard did not access the cache");

    AST_PLAIN_ADDR: assert property (
        @(posedge clk) disable iff (rst)
        go && !use_disp |=> mem_addr[31:1] == $past(first_source_operand[31:1])
    ) else $error("plain form address differs from the source operand");

    AST_DISP_ADDR: assert property (
        @(posedge clk) disable iff (rst)
        go && use_disp |=> mem_addr[31:1] == $past(chk_disp_addr[31:1])
    ) else $error("displacement form address is wrong");

    AST_EVEN_ADDR: assert property (
        @(posedge clk) disable iff (rst)
        mem_req |-> mem_addr[0] == 1'b0
    ) else $error("odd address presented to the cache");

    AST_SIGN_EXT: assert property (
        @(posedge clk) disable iff (rst)
        wb_valid |-> wb_data[31:16] == {16{wb_data[15]}}
    ) else $error("result is not sign-extended");

    AST_LITTLE: assert property (
        @(posedge clk) disable iff (rst)
        go && program_status_word_le |-> ##3 wb_data[15:0] == $past(mem_rd_data)
    ) else $error("little-endian byte order wrong");

    AST_BIG: assert property (
        @(posedge clk) disable iff (rst)
        go && !program_status_word_le
        |-> ##3 wb_data[15:0] == {$past(mem_rd_data[7:0]), $past(mem_rd_data[15:8])}
    ) else $error("big-endian byte order wrong");

    // without a write the destination port must hold, or a false guard could leak
    AST_WB_HOLD: assert property (
        @(posedge clk) disable iff (rst)
        !wb_valid |-> $stable(wb_data) && $stable(wb_dest)
    ) else $error("writeback result moved without a write");

    AST_REQ_CAUSE: assert property (
        @(posedge clk) disable iff (rst)
        mem_req |-> $past(issue_valid && (!guard_present || guard[`GUARD_LSB])
            && (issue_slot == `DMEM_SLOT_LO || issue_slot == `DMEM_SLOT_HI))
    ) else $error("cache access without an accepted op");

    AST_WB_CAUSE: assert property (
        @(posedge clk) disable iff (rst)
        wb_valid |-> $past(mem_req, 2)
    ) else $error("write without a cache access two cycles earlier");
endmodule

/* File: tb/dcache_model.sv */
// data cache model answering halfword reads
`timescale 1ns/10ps

module dcache_model
    import halfword_load_pkg::*;
(
    input wire logic clk,
    input wire logic mem_req,
    input wire word_t mem_addr,
    output half_t mem_rd_data
);
    logic req_seen = 1'b0;
    word_t addr_seen = 32'h0000_0000;
    half_t reply_ff = 16'h0000;
    assign mem_rd_data = reply_ff;
    // memory contents are a hash of the byte address
    function automatic logic [7:0] mb(word_t a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    // capture mid-cycle so the reply lands in the next cycle
    always @(negedge clk) begin
        req_seen = mem_req;
        addr_seen = mem_addr;
    end
    // aperture not decoded; outside replies the data keeps changing
    always @(posedge clk) begin
        #1;
        if (req_seen) begin
            reply_ff = {mb(addr_seen | 32'h1), mb(addr_seen)};
        end else begin
            reply_ff = ~reply_ff;
        end
    end
endmodule

/* File: tb/signed_halfword_load_unit_tb.sv */
// self-checking bench for the signed halfword load unit
`timescale 1ns/10ps

module signed_halfword_load_unit_tb
    import halfword_load_pkg::*;
;
    typedef struct {int due; word_t a; dest_t d; word_t v; logic odd;} op_t;
    logic clk = 1'b0, rst = 1'b1, iv = 1'b0, ud = 1'b0, gp = 1'b0, le = 1'b0;
    slot_t sl = 3'h4;
    word_t src = 32'h0, gd = 32'h0, mem_addr, wb_data, r;
    disp_t dp = 7'h00;
    dest_t dst = 7'h00, wb_dest;
    logic mem_req, wb_valid;
    half_t mem_rd_data;
    int err_count = 0, num_checks = 0, cyc = 0;
    word_t seed = 32'h0000_63F9;
    op_t mq[$], wq[$], mo, wo;
    signed_halfword_load_unit u_dut (.clk(clk), .rst(rst), .issue_valid(iv),
        .issue_slot(sl), .use_disp(ud), .first_source_operand(src), .disp(dp),
        .guard_present(gp), .guard(gd), .dest_idx(dst), .program_status_word_le(le),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
        .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data));
    dcache_model u_mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rd_data(mem_rd_data));
    function automatic word_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] mb(word_t a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    // big endian puts the addressed byte on top
    function automatic word_t expv(word_t a, logic l);
        half_t h;
        h = l ? {mb(a | 32'h1), mb(a & ~32'h1)} : {mb(a & ~32'h1), mb(a | 32'h1)};
        return {{16{h[15]}}, h};
    endfunction
    task automatic chk(string n, word_t e, word_t g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // strobe stays up between ops so no signal is set twice per step
    task automatic issue(logic v, slot_t s, logic u, word_t b, disp_t d, logic p,
        logic g, logic l, dest_t t);
        // the displacement field counts halfwords
        word_t ea;
        ea = b + (u ? {{24{d[6]}}, d, 1'b0} : 32'h0);
        {iv, sl, ud, src, dp, gp, gd, le, dst} = {v, s, u, b, d, p, b[31:1], g, l, t};
        if (v && (s == 3'h4 || s == 3'h5) && (!p || g)) begin
            mq.push_back('{cyc + 3, ea & ~32'h1, t, expv(ea, l), ea[0]});
            wq.push_back('{cyc + 3, ea & ~32'h1, t, expv(ea, l), ea[0]});
        end
        @(posedge clk);
        #1;
    endtask
    always #5 clk = ~clk;
    // hang guard, far above the expected run of about 316 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 1000) begin
            err_count++;
            wrap_up();
        end
    end
    // cache and writeback monitors, refused ops must leave no trace
    always @(negedge clk) if (!rst) begin
        if (mem_req === 1'b1 || (mq.size() > 0 && mq[0].due - 2 == cyc)) begin
            if (mq.size() == 0) chk("mem_req", 32'h0, 32'h1);
            else begin
                mo = mq.pop_front();
                chk("mem_req", 32'h1, 32'(mem_req));
                chk("mem_cyc", 32'(mo.due - 2), 32'(cyc));
                chk("mem_addr", mo.a, mem_addr);
            end
        end
        if (wb_valid === 1'b1 || (wq.size() > 0 && wq[0].due == cyc)) begin
            if (wq.size() == 0) chk("wb_valid", 32'h0, 32'h1);
            else begin
                wo = wq.pop_front();
                chk("wb_valid", 32'h1, 32'(wb_valid));
                chk("wb_cyc", 32'(wo.due), 32'(cyc));
                chk("wb_dest", 32'(wo.d), 32'(wb_dest));
                if (!wo.odd) chk("wb_data", wo.v, wb_data);
            end
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk("rst_out", 32'h0, wb_data | mem_addr | 32'(wb_dest) | {30'h0, wb_valid, mem_req});
        rst = 1'b0;
        @(posedge clk);
        #1;
        issue(1, 3'h4, 0, 32'h0000_0D00, 7'h02, 0, 0, 1, 7'h3C);
        issue(1, 3'h5, 1, 32'h0000_0D04, 7'h7E, 1, 1, 1, 7'h50);
        issue(1, 3'h4, 1, 32'h0000_0D04, 7'h7E, 1, 0, 1, 7'h51);
        issue(1, 3'h3, 0, 32'h0000_0D00, 7'h00, 0, 0, 1, 7'h52);
        issue(1, 3'h4, 1, 32'h0000_1000, 7'h40, 0, 0, 0, 7'h7F);
        issue(1, 3'h5, 1, 32'h0000_0D01, 7'h3F, 0, 0, 0, 7'h01);
        issue(1, 3'h5, 0, 32'hEFFF_0100, 7'h00, 0, 0, 1, 7'h02);
        repeat (300) begin
            r = rnd();
            issue(r[0] | r[1], (r[3] & r[4]) ? r[4:2] : {2'b10, r[2]}, r[5], rnd(),
                r[14:8], r[6], r[7] | r[15], r[16], r[23:17]);
        end
        iv = 1'b0;
        repeat (6) @(posedge clk);
        chk("left", 32'h0, 32'(mq.size() + wq.size()));
        wrap_up();
    end
endmodule
